// ### design/timer_params.svh
/*
 * constants for the overflow timer: register offsets, field positions,
 * reset values and counts.
 * assumes inclusion by bare name from every design file that needs them.
 */
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OFS_LOW        8'h00
`define OFS_HIGH_BUF   8'h04
`define OFS_INT_CTRL   8'h08
`define OFS_TMR_CTRL   8'h0C

// ----------------------------------------
// interrupt control fields
// ----------------------------------------
`define IC_GLOBAL_BIT  7
`define IC_PERIPH_BIT  6
`define IC_OVF_IE_BIT  5
`define IC_OVF_FL_BIT  2
`define IC_RESET       8'h00

// ----------------------------------------
// timer control fields
// ----------------------------------------
`define TC_RUN_BIT     7
`define TC_EIGHT_BIT   6
`define TC_SRC_BIT     5
`define TC_EDGE_BIT    4
`define TC_BYP_BIT     3
`define TC_RATIO_HI    2
`define TC_RESET       8'hFF

// ----------------------------------------
// values and counts
// ----------------------------------------
`define HB_RESET       8'h00
`define CNT_RESET      16'h0000
`define BYTE_MAX       8'hFF
`define WORD_MAX       16'hFFFF
`define HOLDOFF_CYC    2'h2
`define PRE_RESET      8'h00

`endif

// ### design/timer_pkg.sv
/*
 * types shared by the overflow timer modules.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package timer_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [7:0]  addr_t;
  typedef logic [31:0] data_t;
  typedef logic [3:0]  sel_t;
  typedef logic [15:0] count_t;
  typedef logic [2:0]  ratio_t;

  // ----------------------------------------
  // bus slave states
  // ----------------------------------------
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_t;
endpackage

// ### design/count_path_if.sv
/*
 * carrier between the timer core, the edge detector and the prescaler.
 * assumes all three parties run on the same clock.
 */
interface count_path_if;
  logic                  ext_pulse;
  logic                  edge_fall;
  logic                  pre_in;
  logic                  pre_clr;
  logic [2:0]            pre_ratio;
  logic                  pre_tick;

  modport core_mp (input ext_pulse, pre_tick,
                   output edge_fall, pre_in, pre_clr, pre_ratio);
  modport edge_mp (input edge_fall, output ext_pulse);
  modport pre_mp  (input pre_in, pre_clr, pre_ratio, output pre_tick);
endinterface

// ### design/count_edge_detect.sv
/*
 * synchroniser and edge detector for the external count input.
 * assumes the input may change at any time; one pulse per chosen edge.
 */
`include "timer_params.svh"

module count_edge_detect (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ext_count_i,
  count_path_if.edge_mp     cp
);
  import timer_pkg::*;

  logic sync1_ff;
  logic sync2_ff;
  logic prev_ff;
  logic pulse_ff;
  logic nxt_pulse;

  // ----------------------------------------
  // edge choice
  // ----------------------------------------
  always_comb begin
    nxt_pulse = cp.edge_fall ? (prev_ff & ~sync2_ff) : (~prev_ff & sync2_ff);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff  <= 1'b0;
      pulse_ff <= 1'b0;
    end else begin
      sync1_ff <= ext_count_i;
      sync2_ff <= sync1_ff;
      prev_ff  <= sync2_ff;
      pulse_ff <= nxt_pulse;
    end
  end

  assign cp.ext_pulse = pulse_ff;
endmodule

// ### design/timer_prescaler.sv
/*
 * 8-bit prescaler dividing count events by a power of two.
 * assumes pre_in is a one-cycle event and pre_clr a synchronous clear.
 */
`include "timer_params.svh"

module timer_prescaler (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  count_path_if.pre_mp      cp
);
  import timer_pkg::*;

  byte_t pre_ff;
  byte_t nxt_pre;
  byte_t mask;

  // ----------------------------------------
  // ratio mask: code 0 gives 1:2, code 7 gives 1:256
  // ----------------------------------------
  function automatic byte_t ratio_mask(input ratio_t r);
    byte_t m;
    m = '0;
    for (int i = 0; i < 8; i++) begin
      if (i <= int'(r)) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction

  always_comb begin
    mask = ratio_mask(cp.pre_ratio);
    nxt_pre = pre_ff;
    if (cp.pre_clr) begin
      nxt_pre = `PRE_RESET;
    end else if (cp.pre_in) begin
      nxt_pre = pre_ff + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_ff <= `PRE_RESET;
    end else begin
      pre_ff <= nxt_pre;
    end
  end

  assign cp.pre_tick = cp.pre_in & ~cp.pre_clr & ((pre_ff & mask) == mask);
endmodule

// ### design/overflow_timer.sv
/*
 * 8/16-bit overflow timer with buffered high byte, classic Wishbone slave.
 * assumes one clock edge per instruction cycle and synchronous inputs, except ext_count_i, which goes through a two-flop synchroniser.
 */
// Local design decisions: the register offsets and the Wishbone slave port.
`include "timer_params.svh"

module overflow_timer (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire timer_pkg::addr_t wb_adr_i,
  input  wire timer_pkg::sel_t  wb_sel_i,
  input  wire timer_pkg::data_t wb_dat_i,
  output      timer_pkg::data_t wb_dat_o,
  output      logic             wb_ack_o,
  input  wire logic             sleep_i,
  input  wire logic             ext_count_i,
  output      logic             overflow_irq_o
);
  import timer_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  bus_state_t state_ff;
  bus_state_t nxt_state;
  data_t      rdat_ff;
  data_t      nxt_rdat;
  logic       ack_ff;
  logic       nxt_ack;
  count_t     cnt_ff;
  count_t     nxt_cnt;
  byte_t      hb_ff;
  byte_t      nxt_hb;
  byte_t      ic_ff;
  byte_t      nxt_ic;
  byte_t      tc_ff;
  byte_t      nxt_tc;
  logic [1:0] hold_ff;
  logic [1:0] nxt_hold;
  logic       irq_ff;
  logic       nxt_irq;

  logic       take;
  logic       wr_lane;
  logic       lo_wr;
  logic       lo_rd;
  logic       hb_wr;
  logic       ic_wr;
  logic       tc_wr;
  logic       src_evt;
  logic       inc;
  logic       ovf_evt;
  logic       eight;

  count_path_if cp();

  count_edge_detect u_edge (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .ext_count_i (ext_count_i),
    .cp          (cp.edge_mp)
  );

  timer_prescaler u_pre (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .cp    (cp.pre_mp)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic hit(input addr_t a, input addr_t ofs);
    return a == ofs;
  endfunction

  function automatic count_t step(input count_t c, input logic e8);
    count_t r;
    r = c;
    if (e8) begin
      r[7:0] = c[7:0] + 8'h01;
    end else begin
      r = c + 16'h0001;
    end
    return r;
  endfunction

  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  always_comb begin
    take    = wb_cyc_i & wb_stb_i & (state_ff == BUS_IDLE);
    wr_lane = take & wb_we_i & wb_sel_i[0];
    lo_wr   = wr_lane & hit(wb_adr_i, `OFS_LOW);
    hb_wr   = wr_lane & hit(wb_adr_i, `OFS_HIGH_BUF);
    ic_wr   = wr_lane & hit(wb_adr_i, `OFS_INT_CTRL);
    tc_wr   = wr_lane & hit(wb_adr_i, `OFS_TMR_CTRL);
    lo_rd   = take & ~wb_we_i & hit(wb_adr_i, `OFS_LOW);
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_ack   = 1'b0;
    nxt_rdat  = rdat_ff;
    case (state_ff)
      BUS_IDLE: begin
        if (take) begin
          nxt_state = BUS_ACK;
          nxt_ack   = 1'b1;
          nxt_rdat  = '0;
          if (!wb_we_i) begin
            if (hit(wb_adr_i, `OFS_LOW)) begin
              nxt_rdat[7:0] = cnt_ff[7:0];
            end else if (hit(wb_adr_i, `OFS_HIGH_BUF)) begin
              nxt_rdat[7:0] = hb_ff;
            end else if (hit(wb_adr_i, `OFS_INT_CTRL)) begin
              nxt_rdat[7:0] = ic_ff;
            end else if (hit(wb_adr_i, `OFS_TMR_CTRL)) begin
              nxt_rdat[7:0] = tc_ff;
            end
          end
        end
      end
      BUS_ACK: begin
        nxt_state = BUS_IDLE;
      end
      default: begin
        nxt_state = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= BUS_IDLE;
      ack_ff   <= 1'b0;
      rdat_ff  <= '0;
    end else begin
      state_ff <= nxt_state;
      ack_ff   <= nxt_ack;
      rdat_ff  <= nxt_rdat;
    end
  end

  // ----------------------------------------
  // count path
  // ----------------------------------------
  always_comb begin
    eight         = tc_ff[`TC_EIGHT_BIT];
    cp.edge_fall  = tc_ff[`TC_EDGE_BIT];
    cp.pre_ratio  = tc_ff[`TC_RATIO_HI:0];
    src_evt       = tc_ff[`TC_SRC_BIT] ? cp.ext_pulse : 1'b1;
    cp.pre_in     = src_evt & ~tc_ff[`TC_BYP_BIT];
    cp.pre_clr    = (lo_wr | hb_wr) & ~tc_ff[`TC_BYP_BIT];
    inc           = tc_ff[`TC_RUN_BIT] & ~sleep_i & (hold_ff == 2'h0) &
                    (tc_ff[`TC_BYP_BIT] ? src_evt : cp.pre_tick);
    ovf_evt       = inc & ~lo_wr & (eight ? (cnt_ff[7:0] == `BYTE_MAX)
                                          : (cnt_ff == `WORD_MAX));
  end

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_hold = (hold_ff == 2'h0) ? 2'h0 : hold_ff - 2'h1;
    nxt_hb   = hb_ff;
    if (lo_wr) begin
      nxt_cnt  = {hb_ff, wb_dat_i[7:0]};
      nxt_hold = `HOLDOFF_CYC;
    end else if (inc) begin
      nxt_cnt = step(cnt_ff, eight);
    end
    if (hb_wr) begin
      nxt_hb = wb_dat_i[7:0];
    end else if (lo_rd) begin
      nxt_hb = cnt_ff[15:8];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff  <= `CNT_RESET;
      hold_ff <= 2'h0;
      hb_ff   <= `HB_RESET;
    end else begin
      cnt_ff  <= nxt_cnt;
      hold_ff <= nxt_hold;
      hb_ff   <= nxt_hb;
    end
  end

  // ----------------------------------------
  // control and flag
  // ----------------------------------------
  always_comb begin
    nxt_tc = tc_wr ? wb_dat_i[7:0] : tc_ff;
    nxt_ic = ic_ff;
    if (ic_wr) begin
      nxt_ic = '0;
      nxt_ic[`IC_GLOBAL_BIT] = wb_dat_i[`IC_GLOBAL_BIT];
      nxt_ic[`IC_PERIPH_BIT] = wb_dat_i[`IC_PERIPH_BIT];
      nxt_ic[`IC_OVF_IE_BIT] = wb_dat_i[`IC_OVF_IE_BIT];
      nxt_ic[`IC_OVF_FL_BIT] = wb_dat_i[`IC_OVF_FL_BIT];
    end
    if (ovf_evt) begin
      nxt_ic[`IC_OVF_FL_BIT] = 1'b1;
    end
    nxt_irq = nxt_ic[`IC_OVF_FL_BIT] & nxt_ic[`IC_OVF_IE_BIT];
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tc_ff  <= `TC_RESET;
      ic_ff  <= `IC_RESET;
      irq_ff <= 1'b0;
    end else begin
      tc_ff  <= nxt_tc;
      ic_ff  <= nxt_ic;
      irq_ff <= nxt_irq;
    end
  end

  assign wb_dat_o       = rdat_ff;
  assign wb_ack_o       = ack_ff;
  assign overflow_irq_o = irq_ff;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_OVF8: assert property (@(posedge clk_i) disable iff (rst_i)
    ovf_evt && eight |=> ic_ff[`IC_OVF_FL_BIT] && cnt_ff[7:0] == 8'h00)
    else $error("8-bit wrap did not raise flag");

  AST_OVF16: assert property (@(posedge clk_i) disable iff (rst_i)
    ovf_evt && !eight |=> cnt_ff == 16'h0000 && ic_ff[`IC_OVF_FL_BIT])
    else $error("16-bit overflow without full wrap");

  AST_FLAG_SET: assert property (@(posedge clk_i) disable iff (rst_i)
    ovf_evt |=> ic_ff[`IC_OVF_FL_BIT])
    else $error("overflow did not set flag");

  AST_IRQ_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
    overflow_irq_o == (ic_ff[`IC_OVF_FL_BIT] && ic_ff[`IC_OVF_IE_BIT]))
    else $error("interrupt output not gated by enable");

  AST_FLAG_STICKY: assert property (@(posedge clk_i) disable iff (rst_i)
    ic_ff[`IC_OVF_FL_BIT] && !ic_wr |=> ic_ff[`IC_OVF_FL_BIT])
    else $error("flag cleared without software write");

  AST_SLEEP: assert property (@(posedge clk_i) disable iff (rst_i)
    sleep_i && !lo_wr && !ic_wr |=> $stable(cnt_ff) && !$rose(ic_ff[`IC_OVF_FL_BIT]))
    else $error("counted during sleep");

  AST_MODE8: assert property (@(posedge clk_i) disable iff (rst_i)
    inc && eight && !lo_wr |=> cnt_ff[15:8] == $past(cnt_ff[15:8]))
    else $error("high byte moved in 8-bit mode");

  AST_SNAP: assert property (@(posedge clk_i) disable iff (rst_i)
    lo_rd |=> hb_ff == $past(cnt_ff[15:8]) && wb_dat_o[7:0] == $past(cnt_ff[7:0]))
    else $error("high byte snapshot wrong");

  AST_LOAD: assert property (@(posedge clk_i) disable iff (rst_i)
    lo_wr |=> cnt_ff == {$past(hb_ff), $past(wb_dat_i[7:0])})
    else $error("16-bit load wrong");

  AST_TICK: assert property (@(posedge clk_i) disable iff (rst_i)
    tc_ff[`TC_RUN_BIT] && !tc_ff[`TC_SRC_BIT] && tc_ff[`TC_BYP_BIT] && !sleep_i
    && hold_ff == 2'h0 && !lo_wr && !eight |=> cnt_ff == $past(cnt_ff) + 16'h0001)
    else $error("timer mode missed a cycle");

  AST_HOLDOFF: assert property (@(posedge clk_i) disable iff (rst_i)
    lo_wr |=> ##1 $stable(cnt_ff) ##1 $stable(cnt_ff))
    else $error("counted during hold-off");

  AST_PRE_CLR: assert property (@(posedge clk_i) disable iff (rst_i)
    (lo_wr || hb_wr) && !tc_ff[`TC_BYP_BIT] |=> u_pre.pre_ff == `PRE_RESET && $stable(tc_ff))
    else $error("prescaler clear touched assignment");

  AST_ACK: assert property (@(posedge clk_i) disable iff (rst_i)
    take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single cycle");

  COV_OVF8: cover property (@(posedge clk_i) disable iff (rst_i) ovf_evt && eight);
  COV_OVF16: cover property (@(posedge clk_i) disable iff (rst_i) ovf_evt && !eight);
  COV_SNAP: cover property (@(posedge clk_i) disable iff (rst_i) lo_rd);
  COV_EXT: cover property (@(posedge clk_i) disable iff (rst_i)
    inc && tc_ff[`TC_SRC_BIT]);
endmodule

// ### sim/test_overflow_timer.sv
/*
 * self-checking bench for the overflow timer, driven over classic wishbone.
 * assumes the design package, interface and modules are compiled before it.
 */
`include "timer_params.svh"

module test_overflow_timer;
  timeunit 1ns;
  timeprecision 1ps;
  import timer_pkg::*;

  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic   clk_i;
  logic   rst_i;
  logic   wb_cyc_i;
  logic   wb_stb_i;
  logic   wb_we_i;
  addr_t  wb_adr_i;
  sel_t   wb_sel_i;
  data_t  wb_dat_i;
  data_t  wb_dat_o;
  logic   wb_ack_o;
  logic   sleep_i;
  logic   ext_count_i;
  logic   overflow_irq_o;
  integer num_errors;
  integer tests_run;
  integer cycles;
  integer mdl;
  integer n;
  integer wrap;
  byte_t  lfsr;
  byte_t  hb;
  byte_t  lo;

  overflow_timer DUT (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .wb_cyc_i       (wb_cyc_i),
    .wb_stb_i       (wb_stb_i),
    .wb_we_i        (wb_we_i),
    .wb_adr_i       (wb_adr_i),
    .wb_sel_i       (wb_sel_i),
    .wb_dat_i       (wb_dat_i),
    .wb_dat_o       (wb_dat_o),
    .wb_ack_o       (wb_ack_o),
    .sleep_i        (sleep_i),
    .ext_count_i    (ext_count_i),
    .overflow_irq_o (overflow_irq_o)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic byte_t lfsr_next(input byte_t v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  task automatic check(input data_t seen, input data_t exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      num_errors = num_errors + 1;
      $display("mismatch at time %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic we, input addr_t adr, input byte_t dat, input sel_t sel,
                     output data_t q);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= {24'h000000, dat};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wr(input addr_t adr, input byte_t dat);
    data_t q;
    bus(1'b1, adr, dat, 4'hF, q);
  endtask

  task automatic rdc(input addr_t adr, input integer exp);
    data_t q;
    bus(1'b0, adr, 8'h00, 4'hF, q);
    check(q, exp);
  endtask

  task automatic load(input byte_t h, input byte_t l);
    wr(`OFS_HIGH_BUF, h);
    wr(`OFS_LOW, l);
  endtask

  // counting allowed for exactly c edges, then frozen again
  task automatic run(input integer c);
    @(posedge clk_i);
    sleep_i <= 1'b0;
    repeat (c) @(posedge clk_i);
    sleep_i <= 1'b1;
  endtask

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // clock and timeout
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      num_errors = num_errors + 1;
      finish_test();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h00000000;
    sleep_i = 1'b1;
    ext_count_i = 1'b0;
    num_errors = 0;
    tests_run = 0;
    cycles = 0;
    lfsr = 8'h57;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(`OFS_TMR_CTRL, 8'hFF);
    rdc(`OFS_HIGH_BUF, 8'h00);
    rdc(`OFS_INT_CTRL, 8'h00);
    rdc(`OFS_LOW, 8'h00);
    wr(8'h10, 8'h5A);
    rdc(8'h10, 8'h00);
    $display("done: reset and map");
    // random 16-bit loads, runs and snapshots
    wr(`OFS_TMR_CTRL, 8'h88);
    repeat (4) begin
      lfsr = lfsr_next(lfsr);
      hb = lfsr;
      lfsr = lfsr_next(lfsr);
      lo = lfsr;
      n = (lfsr % 40) + 1;
      load(hb, lo);
      run(n);
      mdl = {hb, lo} + n;
      wrap = (mdl > 16'hFFFF) ? 4 : 0;
      mdl = mdl & 16'hFFFF;
      wr(`OFS_HIGH_BUF, ~hb);
      rdc(`OFS_LOW, mdl & 8'hFF);
      rdc(`OFS_HIGH_BUF, mdl >> 8);
      rdc(`OFS_INT_CTRL, wrap);
      wr(`OFS_INT_CTRL, 8'h00);
    end
    $display("done: random loads");
    load(8'h00, 8'hF0);
    run(32);
    rdc(`OFS_LOW, 8'h10);
    rdc(`OFS_HIGH_BUF, 8'h01);
    rdc(`OFS_INT_CTRL, 8'h00);
    load(8'hFF, 8'hF0);
    run(32);
    rdc(`OFS_LOW, 8'h10);
    rdc(`OFS_HIGH_BUF, 8'h00);
    rdc(`OFS_INT_CTRL, 8'h04);
    bus(1'b1, `OFS_HIGH_BUF, 8'hAA, 4'hE, mdl);
    rdc(`OFS_HIGH_BUF, 8'h00);
    $display("done: 16-bit overflow");
    // hold-off after a low write while running
    wr(`OFS_INT_CTRL, 8'h00);
    @(posedge clk_i);
    sleep_i <= 1'b0;
    wr(`OFS_LOW, 8'h10);
    repeat (5) @(posedge clk_i);
    sleep_i <= 1'b1;
    rdc(`OFS_LOW, 8'h14);
    wr(`OFS_TMR_CTRL, 8'h08);
    run(6);
    rdc(`OFS_LOW, 8'h14);
    $display("done: hold-off");
    // 8-bit overflow, flag and mask
    wr(`OFS_INT_CTRL, 8'h20);
    wr(`OFS_TMR_CTRL, 8'hC8);
    load(8'h00, 8'hFD);
    run(5);
    rdc(`OFS_LOW, 8'h02);
    rdc(`OFS_INT_CTRL, 8'h24);
    check(overflow_irq_o, 1'b1);
    run(3);
    rdc(`OFS_INT_CTRL, 8'h24);
    wr(`OFS_INT_CTRL, 8'h20);
    rdc(`OFS_INT_CTRL, 8'h20);
    check(overflow_irq_o, 1'b0);
    wr(`OFS_INT_CTRL, 8'h00);
    wr(`OFS_LOW, 8'hFF);
    run(2);
    rdc(`OFS_INT_CTRL, 8'h04);
    check(overflow_irq_o, 1'b0);
    wr(`OFS_INT_CTRL, 8'h24);
    repeat (2) @(posedge clk_i);
    check(overflow_irq_o, 1'b1);
    wr(`OFS_INT_CTRL, 8'h00);
    wr(`OFS_INT_CTRL, 8'hDB);
    rdc(`OFS_INT_CTRL, 8'hC0);
    check(overflow_irq_o, 1'b0);
    $display("done: 8-bit overflow");
    // every prescale ratio; residue left for the next write to clear
    for (int r = 0; r < 8; r++) begin
      wr(`OFS_TMR_CTRL, byte_t'(8'h80 | r));
      load(8'h00, 8'h00);
      run(3 * (2 << r) + 1);
      rdc(`OFS_LOW, 8'h03);
      rdc(`OFS_HIGH_BUF, 8'h00);
    end
    $display("done: prescaler");
    // external edges, rising then falling
    for (int e = 0; e < 2; e++) begin
      wr(`OFS_TMR_CTRL, e ? 8'hB8 : 8'hA8);
      load(8'h00, 8'h00);
      sleep_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      repeat (5) begin
        ext_count_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        ext_count_i <= 1'b0;
        repeat (4) @(posedge clk_i);
      end
      repeat (8) @(posedge clk_i);
      sleep_i <= 1'b1;
      rdc(`OFS_LOW, 8'h05);
    end
    $display("done: external count");
    finish_test();
  end
endmodule
